// File: include/hwmon_cfg_pkg.sv
// Register map, field positions, reset values and timing for the monitor control bank
package hwmon_cfg_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    // Register offsets
    localparam logic [7:0] OFF_RUN_CONTROL   = 8'h01;
    localparam logic [7:0] OFF_ALARM_STYLE   = 8'h02;
    localparam logic [7:0] OFF_CASE_STATE    = 8'h03;
    localparam logic [7:0] OFF_IRQ_STATUS    = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK      = 8'h05;
    localparam logic [7:0] OFF_ENABLE        = 8'h30;
    localparam logic [7:0] OFF_BASE_UPPER    = 8'h60;
    localparam logic [7:0] OFF_BASE_LOWER    = 8'h61;
    localparam logic [7:0] OFF_IRQ_CHANNEL   = 8'h70;
    // Field positions
    localparam int unsigned BIT_UNIT_ENABLE  = 0;
    localparam int unsigned BIT_POWER_DOWN   = 2;
    localparam int unsigned BIT_FAN_START    = 1;
    localparam int unsigned BIT_VT_START     = 0;
    localparam int unsigned BIT_TONE_ENABLE  = 6;
    localparam int unsigned BIT_OVH_STYLE_LO = 4;
    localparam int unsigned BIT_WAKE_ENABLE  = 2;
    localparam int unsigned BIT_ALERT_LO     = 0;
    localparam int unsigned BIT_INTRUSION    = 0;
    localparam int unsigned IRQ_CASE_OPEN    = 0;
    localparam int unsigned IRQ_OVERHEAT     = 1;
    localparam int unsigned IRQ_ALERT        = 2;
    localparam int unsigned IRQ_BITS         = 3;
    // Reset values
    localparam logic [7:0] RST_ENABLE        = 8'h01;
    localparam logic [7:0] RST_BASE_UPPER    = 8'h02;
    localparam logic [7:0] RST_BASE_LOWER    = 8'h95;
    localparam logic [3:0] RST_IRQ_CHANNEL   = 4'h0;
    localparam logic [2:0] RST_RUN_CONTROL   = 3'h3;
    localparam logic [7:0] RST_ALARM_STYLE   = 8'h00;
    localparam logic       RST_INTRUSION     = 1'b1;
    localparam logic [2:0] RST_IRQ_MASK      = 3'h0;
    // Output styles
    localparam logic [1:0] STYLE_LEVEL       = 2'h0;
    localparam logic [1:0] STYLE_ALT         = 2'h1;
    localparam logic [1:0] STYLE_LED         = 2'h2;
    localparam logic [1:0] STYLE_BEEP        = 2'h3;
    // Timing
    localparam longint unsigned CLK_HZ       = 200_000_000;
    localparam longint unsigned LED_HZ       = 1;
    localparam longint unsigned TONE_LO_HZ   = 400;
    localparam longint unsigned TONE_HI_HZ   = 800;
    localparam longint unsigned PULSE_NS     = 1000;
    localparam longint unsigned LED_HALF_CYC = CLK_HZ / (2 * LED_HZ);
    localparam longint unsigned TONE_HI_HALF = CLK_HZ / (2 * TONE_HI_HZ);
    localparam longint unsigned PULSE_CYC    = (PULSE_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
endpackage

// File: rtl/hwmon_config_alarm_control.sv
// Configuration registers and alarm output control of the hardware monitor
`timescale 1ns/1ps
module hwmon_config_alarm_control #(
    parameter longint unsigned LED_HALF_CYC = hwmon_cfg_pkg::LED_HALF_CYC,
    parameter longint unsigned TONE_HALF    = hwmon_cfg_pkg::TONE_HI_HALF,
    parameter longint unsigned PULSE_CYC    = hwmon_cfg_pkg::PULSE_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       vbat_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic       case_open_pin,
    input  wire logic       overheat_event,
    input  wire logic       alert_event,
    output logic            monitor_unit_enable,
    output logic      [7:0] base_upper_byte,
    output logic      [7:0] base_lower_byte,
    output logic      [3:0] interrupt_channel_field,
    output logic            fan_monitor_run,
    output logic            volt_temp_monitor_run,
    output logic            overheat_out_n,
    output logic            alert_out,
    output logic            beep_out,
    output logic            wake_event_out,
    output logic            irq
);
    localparam int unsigned LED_W  = $clog2(LED_HALF_CYC + 1);
    localparam int unsigned TONE_W = $clog2(2 * TONE_HALF + 1);
    localparam int unsigned PUL_W  = $clog2(PULSE_CYC + 1);

    logic [2:0] run_control;
    logic [7:0] alarm_style;
    logic       intrusion_flag;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [1:0] case_sync;
    logic [1:0] ovh_sync;
    logic [1:0] alert_sync;
    logic       case_seen;
    logic       ovh_seen;
    logic [LED_W-1:0]  led_cnt;
    logic              led_phase;
    logic [TONE_W-1:0] tone_cnt;
    logic [TONE_W-1:0] tone_limit;
    logic              tone_phase;
    logic              tone_slow;
    logic [PUL_W-1:0]  pulse_cnt;
    logic              active;
    logic              case_rise;
    logic              ovh_rise;
    logic              intrusion_tone_enable;
    logic              intrusion_wake_enable;
    logic [1:0]        overheat_output_style;
    logic [1:0]        alert_style;
    logic [2:0]        next_irq_status;
    logic              ovh_on;
    logic              alert_on;

    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = reg_write && (reg_addr == off);
    endfunction

    assign intrusion_tone_enable = alarm_style[hwmon_cfg_pkg::BIT_TONE_ENABLE];
    assign intrusion_wake_enable = alarm_style[hwmon_cfg_pkg::BIT_WAKE_ENABLE];
    assign overheat_output_style = alarm_style[hwmon_cfg_pkg::BIT_OVH_STYLE_LO +: 2];
    assign alert_style           = alarm_style[hwmon_cfg_pkg::BIT_ALERT_LO +: 2];

    // Monitoring runs only when enabled and not powered down
    assign active = monitor_unit_enable
        && !run_control[hwmon_cfg_pkg::BIT_POWER_DOWN];
    assign fan_monitor_run       = active
        && run_control[hwmon_cfg_pkg::BIT_FAN_START];
    assign volt_temp_monitor_run = active
        && run_control[hwmon_cfg_pkg::BIT_VT_START];

    // Pin inputs pass two flops; edges are taken from the second stage
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            case_sync  <= 2'h0;
            ovh_sync   <= 2'h0;
            alert_sync <= 2'h0;
            case_seen  <= 1'b0;
            ovh_seen   <= 1'b0;
        end else begin
            case_sync  <= {case_sync[0], case_open_pin};
            ovh_sync   <= {ovh_sync[0], overheat_event};
            alert_sync <= {alert_sync[0], alert_event};
            case_seen  <= case_sync[1];
            ovh_seen   <= ovh_sync[1];
        end
    end
    assign case_rise = case_sync[1] && !case_seen;
    assign ovh_rise  = ovh_sync[1] && !ovh_seen;

    // An event reaches its pin only while monitoring is active
    assign ovh_on   = active && ovh_sync[1];
    assign alert_on = active && alert_sync[1];

    // Logical-device settings
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            monitor_unit_enable     <= hwmon_cfg_pkg::RST_ENABLE[0];
            base_upper_byte         <= hwmon_cfg_pkg::RST_BASE_UPPER;
            base_lower_byte         <= hwmon_cfg_pkg::RST_BASE_LOWER;
            interrupt_channel_field <= hwmon_cfg_pkg::RST_IRQ_CHANNEL;
        end else begin
            if (wr_hit(hwmon_cfg_pkg::OFF_ENABLE)) begin
                monitor_unit_enable <= reg_wdata[hwmon_cfg_pkg::BIT_UNIT_ENABLE];
            end
            if (wr_hit(hwmon_cfg_pkg::OFF_BASE_UPPER)) begin
                base_upper_byte <= reg_wdata;
            end
            if (wr_hit(hwmon_cfg_pkg::OFF_BASE_LOWER)) begin
                base_lower_byte <= reg_wdata;
            end
            if (wr_hit(hwmon_cfg_pkg::OFF_IRQ_CHANNEL)) begin
                interrupt_channel_field <= reg_wdata[3:0];
            end
        end
    end

    // Monitor control and output style
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_control <= hwmon_cfg_pkg::RST_RUN_CONTROL;
            alarm_style <= hwmon_cfg_pkg::RST_ALARM_STYLE;
        end else begin
            if (wr_hit(hwmon_cfg_pkg::OFF_RUN_CONTROL)) begin
                run_control <= reg_wdata[2:0];
            end
            if (wr_hit(hwmon_cfg_pkg::OFF_ALARM_STYLE)) begin
                alarm_style <= reg_wdata;
            end
        end
    end

    // Battery-domain flag: the battery reset and a high case pin set it to one, sys_rst does not; a write of one clears it while the case pin is low
    always_ff @(posedge core_clk or posedge vbat_rst) begin
        if (vbat_rst) begin
            intrusion_flag <= hwmon_cfg_pkg::RST_INTRUSION;
        end else if (case_sync[1]) begin
            intrusion_flag <= 1'b1;
        end else if (wr_hit(hwmon_cfg_pkg::OFF_CASE_STATE)
                     && reg_wdata[hwmon_cfg_pkg::BIT_INTRUSION]) begin
            intrusion_flag <= 1'b0;
        end
    end

    // Interrupt status: set wins over write-one-to-clear
    always_comb begin
        next_irq_status = irq_status;
        if (wr_hit(hwmon_cfg_pkg::OFF_IRQ_STATUS)) begin
            next_irq_status = irq_status & ~reg_wdata[2:0];
        end
        next_irq_status[hwmon_cfg_pkg::IRQ_CASE_OPEN] =
            next_irq_status[hwmon_cfg_pkg::IRQ_CASE_OPEN] | case_rise;
        next_irq_status[hwmon_cfg_pkg::IRQ_OVERHEAT] =
            next_irq_status[hwmon_cfg_pkg::IRQ_OVERHEAT] | ovh_rise;
        next_irq_status[hwmon_cfg_pkg::IRQ_ALERT] =
            next_irq_status[hwmon_cfg_pkg::IRQ_ALERT] | alert_sync[1];
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_status <= 3'h0;
            irq_mask   <= hwmon_cfg_pkg::RST_IRQ_MASK;
        end else begin
            irq_status <= next_irq_status;
            if (wr_hit(hwmon_cfg_pkg::OFF_IRQ_MASK)) begin
                irq_mask <= reg_wdata[2:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= monitor_unit_enable && |(irq_status & irq_mask);
        end
    end

    // 1 Hz blink divider
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            led_cnt   <= '0;
            led_phase <= 1'b0;
        end else if (led_cnt == LED_W'(LED_HALF_CYC - 1)) begin
            led_cnt   <= '0;
            led_phase <= ~led_phase;
        end else begin
            led_cnt <= led_cnt + 1'b1;
        end
    end

    // Tone alternates 800 Hz and 400 Hz each blink half period
    assign tone_limit = tone_slow ? TONE_W'(2 * TONE_HALF - 1) : TONE_W'(TONE_HALF - 1);
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tone_cnt   <= '0;
            tone_phase <= 1'b0;
            tone_slow  <= 1'b0;
        end else begin
            tone_slow <= led_phase;
            if (tone_cnt >= tone_limit) begin
                tone_cnt   <= '0;
                tone_phase <= ~tone_phase;
            end else begin
                tone_cnt <= tone_cnt + 1'b1;
            end
        end
    end

    // Low pulse on each new overheat event
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pulse_cnt <= '0;
        end else if (ovh_rise) begin
            pulse_cnt <= PUL_W'(PULSE_CYC);
        end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - 1'b1;
        end
    end

    // Alarm pins, registered; idle levels when the monitor is disabled
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            overheat_out_n <= 1'b1;
            alert_out      <= 1'b1;
            beep_out       <= 1'b0;
            wake_event_out <= 1'b0;
        end else begin
            case (overheat_output_style)
                hwmon_cfg_pkg::STYLE_LEVEL: begin
                    overheat_out_n <= !ovh_on;
                end
                hwmon_cfg_pkg::STYLE_ALT: begin
                    // Pulse length is fixed; a held event gives one pulse only
                    overheat_out_n <= !(active && pulse_cnt != '0);
                end
                hwmon_cfg_pkg::STYLE_LED: begin
                    overheat_out_n <= !(ovh_on && led_phase);
                end
                default: begin
                    overheat_out_n <= !(ovh_on && tone_phase);
                end
            endcase
            case (alert_style)
                hwmon_cfg_pkg::STYLE_LEVEL: begin
                    alert_out <= !alert_on;
                end
                hwmon_cfg_pkg::STYLE_ALT: begin
                    alert_out <= alert_on;
                end
                hwmon_cfg_pkg::STYLE_LED: begin
                    alert_out <= !(alert_on && led_phase);
                end
                default: begin
                    alert_out <= !(alert_on && tone_phase);
                end
            endcase
            // Beep follows the flag so it sounds until software clears it
            beep_out       <= monitor_unit_enable && intrusion_tone_enable
                              && intrusion_flag && tone_phase;
            wake_event_out <= monitor_unit_enable && intrusion_wake_enable
                              && case_rise;
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                hwmon_cfg_pkg::OFF_RUN_CONTROL: reg_rdata <= {5'h00, run_control};
                hwmon_cfg_pkg::OFF_ALARM_STYLE: reg_rdata <= alarm_style;
                hwmon_cfg_pkg::OFF_CASE_STATE:  reg_rdata <= {7'h00, intrusion_flag};
                hwmon_cfg_pkg::OFF_IRQ_STATUS:  reg_rdata <= {5'h00, irq_status};
                hwmon_cfg_pkg::OFF_IRQ_MASK:    reg_rdata <= {5'h00, irq_mask};
                hwmon_cfg_pkg::OFF_ENABLE:      reg_rdata <= {7'h00, monitor_unit_enable};
                hwmon_cfg_pkg::OFF_BASE_UPPER:  reg_rdata <= base_upper_byte;
                hwmon_cfg_pkg::OFF_BASE_LOWER:  reg_rdata <= base_lower_byte;
                hwmon_cfg_pkg::OFF_IRQ_CHANNEL: reg_rdata <= {4'h0, interrupt_channel_field};
                default:                        reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// File: tb/hwmon_ctl_asserts.sv
// Port-level checks of the monitor control bank
`timescale 1ns/1ps
module hwmon_ctl_checker (
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       monitor_unit_enable,
    input wire logic [7:0] base_upper_byte,
    input wire logic [7:0] base_lower_byte,
    input wire logic [3:0] interrupt_channel_field,
    input wire logic       fan_monitor_run,
    input wire logic       volt_temp_monitor_run,
    input wire logic       overheat_out_n,
    input wire logic       beep_out,
    input wire logic       wake_event_out,
    input wire logic       irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_en_wr;
        reg_write && reg_addr == 8'h30 |=> monitor_unit_enable == $past(reg_wdata[0]);
    endproperty
    property p_hi_wr;
        reg_write && reg_addr == 8'h60 |=> base_upper_byte == $past(reg_wdata);
    endproperty
    property p_lo_wr;
        reg_write && reg_addr == 8'h61 |=> base_lower_byte == $past(reg_wdata);
    endproperty
    property p_ch_wr;
        reg_write && reg_addr == 8'h70 |=> interrupt_channel_field == $past(reg_wdata[3:0]);
    endproperty
    // Upper nibble is reserved and must read back as zero
    property p_ch_rd;
        reg_read && reg_addr == 8'h70 |=> reg_rdata == {4'h0, interrupt_channel_field};
    endproperty
    property p_rd_idle;
        !$past(reg_read) |-> reg_rdata == 8'h00;
    endproperty
    property p_off;
        !monitor_unit_enable |-> !fan_monitor_run && !volt_temp_monitor_run;
    endproperty
    // Outputs are registered, so a disabled unit is idle one cycle later
    property p_idle;
        !$past(monitor_unit_enable) |-> !beep_out && !wake_event_out && overheat_out_n && !irq;
    endproperty
    property p_wake_one;
        wake_event_out |=> !wake_event_out;
    endproperty
    a_en_wr: assert property (p_en_wr) else $error("enable not written");
    a_hi_wr: assert property (p_hi_wr) else $error("upper base not written");
    a_lo_wr: assert property (p_lo_wr) else $error("lower base not written");
    a_ch_wr: assert property (p_ch_wr) else $error("channel not written");
    a_ch_rd: assert property (p_ch_rd) else $error("channel readback wrong");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    a_off: assert property (p_off) else $error("monitor runs while disabled");
    a_idle: assert property (p_idle) else $error("outputs active while disabled");
    a_wake_one: assert property (p_wake_one) else $error("wake pulse too long");
    c_wake: cover property (wake_event_out);
    c_irq: cover property ($rose(irq));
    c_beep: cover property ($changed(beep_out));
endmodule

bind hwmon_config_alarm_control hwmon_ctl_checker u_hwmon_ctl_checker (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .monitor_unit_enable(monitor_unit_enable), .base_upper_byte(base_upper_byte),
    .base_lower_byte(base_lower_byte), .interrupt_channel_field(interrupt_channel_field),
    .fan_monitor_run(fan_monitor_run), .volt_temp_monitor_run(volt_temp_monitor_run),
    .overheat_out_n(overheat_out_n), .beep_out(beep_out), .wake_event_out(wake_event_out),
    .irq(irq)
);

// File: tb/tb_top.sv
// Self-checking bench for the monitor control bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    typedef struct { logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp; } row_s;
    logic       core_clk, sys_rst, vbat_rst, reg_write, reg_read, case_open_pin;
    logic       overheat_event, alert_event, monitor_unit_enable, fan_monitor_run;
    logic       volt_temp_monitor_run, overheat_out_n, alert_out, beep_out, wake_event_out, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, base_upper_byte, base_lower_byte, rv;
    logic [3:0] interrupt_channel_field;
    int         fails, n_compared, lows, togs;
    logic       style_ok;
    // Reset reads first, then writes with readback; reserved bits and an unmapped place
    row_s rows[19] = '{'{0, 8'h30, 0, 8'h01}, '{0, 8'h60, 0, 8'h02}, '{0, 8'h61, 0, 8'h95},
        '{0, 8'h70, 0, 8'h00}, '{0, 8'h01, 0, 8'h03}, '{0, 8'h02, 0, 8'h00},
        '{0, 8'h03, 0, 8'h01}, '{0, 8'h05, 0, 8'h00}, '{1, 8'h60, 8'ha5, 8'ha5},
        '{1, 8'h61, 8'h5a, 8'h5a}, '{1, 8'h70, 8'hff, 8'h0f}, '{1, 8'h01, 8'hff, 8'h07},
        '{1, 8'h01, 8'h03, 8'h03}, '{1, 8'h02, 8'hff, 8'hff}, '{1, 8'h02, 8'h00, 8'h00},
        '{1, 8'h30, 8'h00, 8'h00}, '{1, 8'h30, 8'h01, 8'h01}, '{1, 8'h40, 8'hff, 8'h00},
        '{1, 8'h05, 8'h00, 8'h00}};
    // Style rows: overheat 00..11, then alert 00..11, over 100 cycles of active event
    int lo_min[8] = '{94, 3, 30, 30, 94, 1, 30, 30};
    int lo_max[8] = '{99, 3, 70, 70, 99, 6, 70, 70};
    int tg_min[8] = '{1, 2, 4, 10, 1, 1, 4, 10};
    int tg_max[8] = '{1, 2, 6, 26, 1, 2, 7, 27};

    // Long counts shortened so blink and tone show within a short run
    hwmon_config_alarm_control #(.LED_HALF_CYC(20), .TONE_HALF(4), .PULSE_CYC(3))
        u_hwmon_config_alarm_control (
        .core_clk(core_clk), .sys_rst(sys_rst), .vbat_rst(vbat_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .case_open_pin(case_open_pin), .overheat_event(overheat_event),
        .alert_event(alert_event), .monitor_unit_enable(monitor_unit_enable),
        .base_upper_byte(base_upper_byte), .base_lower_byte(base_lower_byte),
        .interrupt_channel_field(interrupt_channel_field), .fan_monitor_run(fan_monitor_run),
        .volt_temp_monitor_run(volt_temp_monitor_run), .overheat_out_n(overheat_out_n),
        .alert_out(alert_out), .beep_out(beep_out), .wake_event_out(wake_event_out), .irq(irq));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic logic pick(int sel);
        case (sel)
            0: pick = overheat_out_n;
            1: pick = alert_out;
            2: pick = beep_out;
            default: pick = wake_event_out;
        endcase
    endfunction

    task automatic count(input int sel, input int n);
        logic prev, cur;
        lows = 0;
        togs = 0;
        prev = pick(sel);
        repeat (n) begin
            @(posedge core_clk);
            #1 cur = pick(sel);
            lows += (cur === 1'b0);
            togs += (cur !== prev);
            prev = cur;
        end
    endtask

    task automatic finish_test;
        if (fails == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // A hang ends the run as a failure
    initial begin
        #400000;
        fails++;
        finish_test();
    end

    initial begin
        {sys_rst, vbat_rst, reg_write, reg_read, reg_addr, reg_wdata} = {2'b11, 18'h0};
        {case_open_pin, overheat_event, alert_event, fails, n_compared} = '0;
        repeat (4) @(posedge core_clk);
        `CHK("ovh idle", 1'b1, overheat_out_n);
        sys_rst <= 1'b0;
        vbat_rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr)
                wr(rows[i].addr, rows[i].data);
            rd(rows[i].addr, rv);
            `CHK("register", rows[i].exp, rv);
        end
        wr(8'h01, 8'h02);
        `CHK("fan run", 1'b1, fan_monitor_run);
        `CHK("vt run", 1'b0, volt_temp_monitor_run);
        wr(8'h01, 8'h01);
        `CHK("run pair", 2'b01, {fan_monitor_run, volt_temp_monitor_run});
        wr(8'h01, 8'h07);
        `CHK("run pair", 2'b00, {fan_monitor_run, volt_temp_monitor_run});
        wr(8'h01, 8'h03);
        for (int s = 0; s < 8; s++) begin
            wr(8'h02, s < 4 ? 8'(s << 4) : 8'(s - 4));
            if (s < 4)
                overheat_event <= 1'b1;
            else
                alert_event <= 1'b1;
            count(s / 4, 100);
            overheat_event <= 1'b0;
            alert_event <= 1'b0;
            style_ok = lows inside {[lo_min[s]:lo_max[s]]}
                       && togs inside {[tg_min[s]:tg_max[s]]};
            `CHK("style", 1'b1, style_ok);
            count(0, 10);
        end
        wr(8'h03, 8'h01);
        rd(8'h03, rv);
        `CHK("case flag", 8'h00, rv);
        sys_rst <= 1'b1;
        @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(8'h03, rv);
        `CHK("case flag", 8'h00, rv);
        wr(8'h02, 8'h04);
        wr(8'h05, 8'h01);
        case_open_pin <= 1'b1;
        count(3, 10);
        `CHK("wake pulses", 1, 10 - lows);
        `CHK("irq", 1'b1, irq);
        rd(8'h04, rv);
        `CHK("irq status", 8'h01, rv);
        count(2, 10);
        `CHK("beep toggles", 0, togs);
        wr(8'h02, 8'h44);
        count(2, 40);
        `CHK("beep tone", 1'b1, togs >= 4);
        wr(8'h03, 8'h01);
        rd(8'h03, rv);
        `CHK("case flag", 8'h01, rv);
        case_open_pin <= 1'b0;
        count(2, 4);
        wr(8'h03, 8'h01);
        rd(8'h03, rv);
        `CHK("case flag", 8'h00, rv);
        wr(8'h05, 8'h00);
        count(2, 3);
        `CHK("irq masked", 1'b0, irq);
        `CHK("beep off", 1'b0, beep_out);
        wr(8'h04, 8'h07);
        wr(8'h02, 8'h00);
        case_open_pin <= 1'b1;
        count(3, 10);
        `CHK("wake pulses", 0, 10 - lows);
        `CHK("beep off", 1'b0, beep_out);
        case_open_pin <= 1'b0;
        wr(8'h30, 8'h00);
        overheat_event <= 1'b1;
        count(0, 10);
        `CHK("ovh disabled", 0, lows);
        overheat_event <= 1'b0;
        wr(8'h03, 8'h01);
        rd(8'h03, rv);
        `CHK("case flag", 8'h00, rv);
        vbat_rst <= 1'b1;
        @(posedge core_clk);
        vbat_rst <= 1'b0;
        rd(8'h03, rv);
        `CHK("case flag", 8'h01, rv);
        finish_test();
    end
endmodule
